// *** hdl/msr_pkg.sv ***
package msr_pkg;
  // register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_SPEED_HI = 8'h11;
  localparam logic [7:0] ADDR_SPEED_LO = 8'h12;
  localparam logic [7:0] ADDR_PERIOD_HI = 8'h13;
  localparam logic [7:0] ADDR_PERIOD_LO = 8'h14;
  localparam logic [7:0] ADDR_KT_HI = 8'h15;
  localparam logic [7:0] ADDR_KT_LO = 8'h16;
  localparam logic [7:0] ADDR_SECTOR = 8'h19;
  localparam logic [7:0] ADDR_RAIL = 8'h1A;
  localparam logic [7:0] ADDR_REQ_LEVEL = 8'h1B;
  localparam logic [7:0] ADDR_APP_LEVEL = 8'h1C;
  // status field positions
  localparam int STAT_THERMAL_BIT = 7;
  localparam int STAT_SLEEP_BIT = 6;
  localparam int STAT_CURRENT_BIT = 5;
  localparam int STAT_LOCKED_BIT = 4;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // open-loop tach options
  localparam logic [1:0] TACH_OL_TOGGLE = 2'h0;
  localparam logic [1:0] TACH_OL_HIGH = 2'h1;
  localparam logic [1:0] TACH_OL_FIRST = 2'h2;
  // timing: one period count is 10 us at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int PERIOD_LSB_US = 10;
  localparam int TICK_CYCLES = (PERIOD_LSB_US * 1000) / CLK_PERIOD_NS;
  localparam logic [9:0] TICK_LAST = 10'(TICK_CYCLES - 1);
  // speed counts = 10 per Hz, so speed = 10 / (period * 10e-6) = 1e6 / period
  localparam int SPEED_PER_HZ = 10;
  localparam logic [19:0] SPEED_NUMER = 20'(SPEED_PER_HZ * 100000);
  localparam logic [4:0] DIV_STEPS = 5'h13;
  // sector codes for 0..300 degrees in 60 degree steps
  localparam logic [7:0] SECTOR_CODE [6] = '{8'h00, 8'h2B, 8'h55, 8'h80, 8'hAB, 8'hD5};

  typedef struct packed {
    logic thermal_alarm;
    logic sleep_standby;
    logic excess_current;
    logic lock_trip;
  } msr_flags_t;

  typedef struct packed {
    logic [15:0] bemf_constant;
    logic bemf_valid;
    logic [2:0] sector_index;
    logic [7:0] advance_offset;
    logic position_done;
    logic [7:0] rail_sample;
    logic rail_valid;
    logic [7:0] requested_level;
    logic [7:0] applied_level;
  } msr_meas_t;

  typedef struct packed {
    logic rd_en;
    logic [7:0] addr;
  } msr_rd_req_t;
endpackage

// *** hdl/msr_motor_status_readback.sv ***
`timescale 1ns/1ps
module msr_motor_status_readback
  import msr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire msr_pkg::msr_flags_t flags_in,
  input wire msr_pkg::msr_meas_t meas_in,
  input wire logic spinning_in,
  input wire logic zero_cross_in,
  input wire logic open_loop_in,
  input wire logic drive_toggle_in,
  input wire logic start_in,
  input wire logic [1:0] open_loop_tach_select_in,
  input wire msr_pkg::msr_rd_req_t rd_req_in,
  output logic [7:0] rd_data_out,
  output logic tach_pulse_out
);
  import msr_pkg::*;

  typedef enum logic [1:0] {
    MSR_DIV_IDLE = 2'b01,
    MSR_DIV_RUN = 2'b10
  } msr_div_state_t;

  function automatic logic [7:0] msr_sector_code(input logic [2:0] idx, input logic [7:0] adv);
    logic [7:0] base;
    base = (idx < 3'd6) ? SECTOR_CODE[idx] : RST_BYTE;
    return base + adv;
  endfunction

  logic thermal_alarm_flag_q, thermal_alarm_flag_d, sleep_flag_q, sleep_flag_d;
  logic excess_current_flag_q, excess_current_flag_d, rotor_locked_flag_q, rotor_locked_flag_d;
  logic [15:0] period_q, period_d, period_cnt_q, period_cnt_d, speed_q, speed_d, kt_q, kt_d;
  logic [9:0] tick_q, tick_d;
  logic [7:0] sector_q, sector_d, rail_q, rail_d, req_level_q, req_level_d;
  logic [7:0] app_level_q, app_level_d, low_byte_snapshot_q, low_byte_snapshot_d;
  logic [7:0] rd_data_q, rd_data_d;
  msr_div_state_t div_state_q, div_state_d;
  logic [19:0] div_num_q, div_num_d, div_quo_q, div_quo_d;
  logic [16:0] div_rem_q, div_rem_d, rem_shift;
  logic [15:0] div_den_q, div_den_d;
  logic [4:0] div_cnt_q, div_cnt_d;
  logic tach_q, tach_d, seen_start_q, seen_start_d, later_start_q, later_start_d;

  always_comb
  begin
    thermal_alarm_flag_d = flags_in.thermal_alarm;
    sleep_flag_d = flags_in.sleep_standby;
    excess_current_flag_d = flags_in.excess_current;
    rotor_locked_flag_d = rotor_locked_flag_q;
    if (start_in)
      rotor_locked_flag_d = 1'b0;
    if (flags_in.lock_trip)
      rotor_locked_flag_d = 1'b1;
    tick_d = tick_q;
    period_cnt_d = period_cnt_q;
    period_d = period_q;
    if (spinning_in)
    begin
      tick_d = (tick_q == TICK_LAST) ? 10'h000 : tick_q + 10'h001;
      if (tick_q == TICK_LAST && period_cnt_q != 16'hFFFF)
      begin
        period_cnt_d = period_cnt_q + 16'h0001;
      end
      if (zero_cross_in)
      begin
        period_d = period_cnt_q;
        period_cnt_d = RST_WORD;
        tick_d = 10'h000;
      end
    end
    else
    begin
      tick_d = 10'h000;
      period_cnt_d = RST_WORD;
    end
    kt_d = kt_q;
    if (meas_in.bemf_valid)
      kt_d = meas_in.bemf_constant;
    sector_d = sector_q;
    if (meas_in.position_done)
      sector_d = msr_sector_code(meas_in.sector_index, meas_in.advance_offset);
    rail_d = rail_q;
    if (meas_in.rail_valid)
      rail_d = meas_in.rail_sample;
    req_level_d = meas_in.requested_level;
    app_level_d = meas_in.applied_level;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      thermal_alarm_flag_q <= 1'b0;
      sleep_flag_q <= 1'b0;
      excess_current_flag_q <= 1'b0;
      rotor_locked_flag_q <= 1'b0;
      tick_q <= 10'h000;
      period_cnt_q <= RST_WORD;
      period_q <= RST_WORD;
      kt_q <= RST_WORD;
      sector_q <= RST_BYTE;
      rail_q <= RST_BYTE;
      req_level_q <= RST_BYTE;
      app_level_q <= RST_BYTE;
    end
    else
    begin
      thermal_alarm_flag_q <= thermal_alarm_flag_d;
      sleep_flag_q <= sleep_flag_d;
      excess_current_flag_q <= excess_current_flag_d;
      rotor_locked_flag_q <= rotor_locked_flag_d;
      tick_q <= tick_d;
      period_cnt_q <= period_cnt_d;
      period_q <= period_d;
      kt_q <= kt_d;
      sector_q <= sector_d;
      rail_q <= rail_d;
      req_level_q <= req_level_d;
      app_level_q <= app_level_d;
    end
  end

  // speed = 1e6 / period, restoring division
  always_comb
  begin
    div_state_d = div_state_q;
    div_num_d = div_num_q;
    div_rem_d = div_rem_q;
    div_quo_d = div_quo_q;
    div_den_d = div_den_q;
    div_cnt_d = div_cnt_q;
    speed_d = speed_q;
    rem_shift = {div_rem_q[15:0], div_num_q[19]};
    unique case (div_state_q)
      MSR_DIV_IDLE:
      begin
        if (spinning_in && zero_cross_in && period_cnt_q != RST_WORD)
        begin
          div_state_d = MSR_DIV_RUN;
          div_num_d = SPEED_NUMER;
          div_rem_d = 17'h0_0000;
          div_quo_d = 20'h0_0000;
          div_den_d = period_cnt_q;
          div_cnt_d = DIV_STEPS;
        end
      end
      MSR_DIV_RUN:
      begin
        div_num_d = {div_num_q[18:0], 1'b0};
        if (rem_shift >= {1'b0, div_den_q})
        begin
          div_rem_d = rem_shift - {1'b0, div_den_q};
          div_quo_d = {div_quo_q[18:0], 1'b1};
        end
        else
        begin
          div_rem_d = rem_shift;
          div_quo_d = {div_quo_q[18:0], 1'b0};
        end
        div_cnt_d = div_cnt_q - 5'h01;
        if (div_cnt_q == 5'h00)
        begin
          div_state_d = MSR_DIV_IDLE;
          speed_d = (div_quo_d[19:16] != 4'h0) ? 16'hFFFF : div_quo_d[15:0];
        end
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      div_state_q <= MSR_DIV_IDLE;
      div_num_q <= 20'h0_0000;
      div_rem_q <= 17'h0_0000;
      div_quo_q <= 20'h0_0000;
      div_den_q <= RST_WORD;
      div_cnt_q <= 5'h00;
      speed_q <= RST_WORD;
    end
    else
    begin
      div_state_q <= div_state_d;
      div_num_q <= div_num_d;
      div_rem_q <= div_rem_d;
      div_quo_q <= div_quo_d;
      div_den_q <= div_den_d;
      div_cnt_q <= div_cnt_d;
      speed_q <= speed_d;
    end
  end

  always_comb
  begin
    low_byte_snapshot_d = low_byte_snapshot_q;
    rd_data_d = rd_data_q;
    if (rd_req_in.rd_en)
    begin
      unique case (rd_req_in.addr)
        ADDR_STATUS:
        begin
          rd_data_d = RST_BYTE;
          rd_data_d[STAT_THERMAL_BIT] = thermal_alarm_flag_q;
          rd_data_d[STAT_SLEEP_BIT] = sleep_flag_q;
          rd_data_d[STAT_CURRENT_BIT] = excess_current_flag_q;
          rd_data_d[STAT_LOCKED_BIT] = rotor_locked_flag_q;
        end
        ADDR_SPEED_HI:
        begin
          rd_data_d = speed_q[15:8];
          low_byte_snapshot_d = speed_q[7:0];
        end
        ADDR_PERIOD_HI:
        begin
          rd_data_d = period_q[15:8];
          low_byte_snapshot_d = period_q[7:0];
        end
        ADDR_KT_HI:
        begin
          rd_data_d = kt_q[15:8];
          low_byte_snapshot_d = kt_q[7:0];
        end
        // low reads use the held snapshot
        ADDR_SPEED_LO, ADDR_PERIOD_LO, ADDR_KT_LO: rd_data_d = low_byte_snapshot_q;
        ADDR_SECTOR: rd_data_d = sector_q;
        ADDR_RAIL: rd_data_d = rail_q;
        ADDR_REQ_LEVEL: rd_data_d = req_level_q;
        ADDR_APP_LEVEL: rd_data_d = app_level_q;
        default: rd_data_d = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      low_byte_snapshot_q <= RST_BYTE;
      rd_data_q <= RST_BYTE;
    end
    else
    begin
      low_byte_snapshot_q <= low_byte_snapshot_d;
      rd_data_q <= rd_data_d;
    end
  end

  always_comb
  begin
    seen_start_d = seen_start_q;
    later_start_d = later_start_q;
    tach_d = tach_q;
    if (start_in)
    begin
      seen_start_d = 1'b1;
      later_start_d = seen_start_q;
    end
    if (rotor_locked_flag_q)
    begin
      tach_d = 1'b1;
    end
    else if (open_loop_in && open_loop_tach_select_in == TACH_OL_HIGH)
    begin
      tach_d = 1'b1;
    end
    else if (open_loop_in && open_loop_tach_select_in == TACH_OL_FIRST && later_start_q)
    begin
      tach_d = 1'b1;
    end
    else if (drive_toggle_in)
    begin
      tach_d = ~tach_q;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      seen_start_q <= 1'b0;
      later_start_q <= 1'b0;
      tach_q <= 1'b1;
    end
    else
    begin
      seen_start_q <= seen_start_d;
      later_start_q <= later_start_d;
      tach_q <= tach_d;
    end
  end

  assign rd_data_out = rd_data_q;
  assign tach_pulse_out = tach_q;
endmodule

// *** testbench/msr_readback_asserts.sv ***
`timescale 1ns/1ps
module msr_readback_asserts
  import msr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire msr_pkg::msr_flags_t flags_in,
  input wire msr_pkg::msr_meas_t meas_in,
  input wire logic spinning_in,
  input wire logic zero_cross_in,
  input wire logic open_loop_in,
  input wire logic drive_toggle_in,
  input wire logic start_in,
  input wire logic [1:0] open_loop_tach_select_in,
  input wire msr_pkg::msr_rd_req_t rd_req_in,
  input wire logic [7:0] rd_data_out,
  input wire logic tach_pulse_out
);
  logic lk_d, lk_q;
  logic [1:0] ns_d, ns_q;
  logic ol_sel2;
  // shadow of the locked flag and of the start count
  always_comb
  begin
    lk_d = flags_in.lock_trip | (lk_q & !start_in);
    ns_d = (start_in && ns_q != 2'h2) ? ns_q + 2'h1 : ns_q;
    ol_sel2 = open_loop_in && open_loop_tach_select_in == TACH_OL_FIRST;
  end
  always_ff @(posedge clk_in)
  begin
    lk_q <= rst_n_in ? lk_d : 1'b0;
    ns_q <= rst_n_in ? ns_d : 2'h0;
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_lock_tach_high: assert property (
    flags_in.lock_trip && !start_in ##1 !start_in |=> tach_pulse_out)
    else $error("tach not high while locked");
  a_status_read: assert property (
    rd_req_in.rd_en && rd_req_in.addr == ADDR_STATUS |=> rd_data_out[3:0] == 4'h0
    && rd_data_out[4] == $past(lk_q) && rd_data_out[7:5] == $past(flags_in[3:1], 2))
    else $error("status byte wrong");
  a_unmapped_zero: assert property (
    rd_req_in.rd_en && rd_req_in.addr inside {8'h17, 8'h18, 8'h1D, 8'h1E}
    |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_data_stands: assert property (
    !rd_req_in.rd_en |=> $stable(rd_data_out))
    else $error("read data moved without read");
  a_drive_toggle: assert property (
    drive_toggle_in && !lk_q && !flags_in.lock_trip && (!open_loop_in ||
    open_loop_tach_select_in == TACH_OL_TOGGLE) |=> tach_pulse_out != $past(tach_pulse_out))
    else $error("tach did not toggle");
  a_open_loop_high: assert property (
    open_loop_in && open_loop_tach_select_in == TACH_OL_HIGH |=> tach_pulse_out)
    else $error("tach not held high");
  a_restart_hold: assert property (
    ol_sel2 && ns_q == 2'h2 |=> tach_pulse_out)
    else $error("tach not high on restart");
  a_first_start_toggle: assert property (
    ol_sel2 && ns_q == 2'h1 && !start_in && drive_toggle_in && !lk_q && !flags_in.lock_trip
    |=> tach_pulse_out != $past(tach_pulse_out))
    else $error("tach did not toggle on first start");
  c_lock_read: cover property (lk_q && rd_req_in.rd_en && rd_req_in.addr == ADDR_STATUS);
  c_restart: cover property (ol_sel2 && ns_q == 2'h2);
  c_zero_cross: cover property (zero_cross_in && spinning_in);
endmodule
bind msr_motor_status_readback msr_readback_asserts chk_u (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .flags_in(flags_in), .meas_in(meas_in), .spinning_in(spinning_in),
  .zero_cross_in(zero_cross_in), .open_loop_in(open_loop_in),
  .drive_toggle_in(drive_toggle_in), .start_in(start_in),
  .open_loop_tach_select_in(open_loop_tach_select_in), .rd_req_in(rd_req_in),
  .rd_data_out(rd_data_out), .tach_pulse_out(tach_pulse_out));

// *** testbench/msr_host_model.sv ***
`timescale 1ns/1ps
module msr_host_model
  import msr_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] rd_data_in,
  output msr_pkg::msr_rd_req_t rd_req_out
);
  initial rd_req_out = '0;
  // one read: strobe held over one rising edge, data taken a cycle later
  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_in);
    rd_req_out.rd_en = 1'b1;
    rd_req_out.addr = addr;
    @(negedge clk_in);
    data = rd_data_in;
    rd_req_out.rd_en = 1'b0;
    rd_req_out.addr = ~addr;
  endtask
endmodule

// *** testbench/tb_motor_status_readback.sv ***
`timescale 1ns/1ps
module tb_motor_status_readback;
  import msr_pkg::*;
  logic clk_in, rst_n_in, spinning_in, zero_cross_in, open_loop_in, drive_toggle_in, start_in;
  logic [1:0] open_loop_tach_select_in;
  msr_flags_t flags_in;
  msr_meas_t meas_in;
  msr_rd_req_t rd_req_in;
  logic [7:0] rd_data_out;
  logic tach_pulse_out;
  int n_mismatch, n_tests;
  logic [7:0] sect [6] = '{8'h00, 8'h2B, 8'h55, 8'h80, 8'hAB, 8'hD5};
  msr_motor_status_readback dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .flags_in(flags_in), .meas_in(meas_in), .spinning_in(spinning_in),
    .zero_cross_in(zero_cross_in), .open_loop_in(open_loop_in),
    .drive_toggle_in(drive_toggle_in), .start_in(start_in),
    .open_loop_tach_select_in(open_loop_tach_select_in), .rd_req_in(rd_req_in),
    .rd_data_out(rd_data_out), .tach_pulse_out(tach_pulse_out));
  msr_host_model host_u (.clk_in(clk_in), .rd_data_in(rd_data_out), .rd_req_out(rd_req_in));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host_u.read_byte(addr, d);
    check($sformatf("reg %h", addr), exp, d);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic tog_chk(input logic e);
    pulse(drive_toggle_in);
    check("tach", {7'h00, e}, {7'h00, tach_pulse_out});
  endtask
  task automatic close_out;
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #900_000;
    n_mismatch++;
    $display("Error watchdog expected done seen timeout");
    close_out();
  end
  initial
  begin
    n_mismatch = 0;
    n_tests = 0;
    rst_n_in = 1'b0;
    flags_in = '0;
    meas_in = '0;
    {spinning_in, zero_cross_in, open_loop_in, drive_toggle_in, start_in} = 5'h00;
    open_loop_tach_select_in = TACH_OL_TOGGLE;
    cyc(8);
    rst_n_in = 1'b1;
    for (logic [7:0] a = 8'h10; a != 8'h1F; a++)
      rd_chk(a, 8'h00);
    tog_chk(1'b0);
    open_loop_in = 1'b1;
    tog_chk(1'b1);
    tog_chk(1'b0);
    open_loop_tach_select_in = TACH_OL_HIGH;
    tog_chk(1'b1);
    tog_chk(1'b1);
    open_loop_tach_select_in = TACH_OL_FIRST;
    pulse(start_in);
    tog_chk(1'b0);
    pulse(start_in);
    cyc(1);
    tog_chk(1'b1);
    open_loop_in = 1'b0;
    open_loop_tach_select_in = TACH_OL_TOGGLE;
    tog_chk(1'b0);
    flags_in = 4'hB;
    cyc(1);
    flags_in.lock_trip = 1'b0;
    cyc(2);
    rd_chk(ADDR_STATUS, 8'hB0);
    tog_chk(1'b1);
    flags_in = 4'h4;
    pulse(start_in);
    cyc(1);
    rd_chk(ADDR_STATUS, 8'h40);
    tog_chk(1'b0);
    spinning_in = 1'b1;
    pulse(zero_cross_in);
    cyc(20499);
    pulse(zero_cross_in);
    cyc(30);
    rd_chk(ADDR_PERIOD_HI, 8'h00);
    rd_chk(ADDR_PERIOD_LO, 8'h14);
    rd_chk(ADDR_SPEED_HI, 8'hC3);
    cyc(25499);
    pulse(zero_cross_in);
    cyc(30);
    rd_chk(ADDR_SPEED_LO, 8'h50);
    rd_chk(ADDR_SPEED_HI, 8'h9C);
    rd_chk(ADDR_SPEED_LO, 8'h40);
    meas_in.bemf_constant = 16'h1234;
    meas_in.bemf_valid = 1'b1;
    meas_in.rail_sample = 8'hA5;
    meas_in.rail_valid = 1'b1;
    meas_in.requested_level = 8'hFF;
    meas_in.applied_level = 8'h80;
    cyc(1);
    meas_in.bemf_valid = 1'b0;
    meas_in.rail_valid = 1'b0;
    rd_chk(ADDR_KT_HI, 8'h12);
    rd_chk(ADDR_KT_LO, 8'h34);
    rd_chk(ADDR_RAIL, 8'hA5);
    rd_chk(ADDR_REQ_LEVEL, 8'hFF);
    rd_chk(ADDR_APP_LEVEL, 8'h80);
    rd_chk(8'h1D, 8'h00);
    meas_in.advance_offset = 8'h2C;
    for (int i = 0; i < 6; i++)
    begin
      meas_in.sector_index = 3'(i);
      meas_in.position_done = 1'b1;
      cyc(1);
      meas_in.position_done = 1'b0;
      rd_chk(ADDR_SECTOR, sect[i] + 8'h2C);
    end
    close_out();
  end
endmodule
